//--- hdl/rtcwk_pkg.sv
// rtcwk_pkg: constants and types shared by the always-on time counter and wake-up control.
// assumes a single 40 MHz clock; the low-power oscillator tick arrives as an enable from a divider.
package rtcwk_pkg;
   localparam int RTC_CNT_W       = 48;            // stored counter width
   localparam int RTC_EFF_W       = 46;            // effective counter bits
   localparam int WAKE1_W         = 32;            // first wake-up counter width
   localparam int WAKE2_W         = 34;            // second wake-up counter width
   localparam int RAM_WORDS       = 128;
   localparam int RAM_WORD_W      = 32;
   localparam int RAM_ADDR_W      = 7;
   localparam real CLK_FREQ_HZ    = 40.0e6;
   localparam real LPO_FREQ_HZ    = 32768.0;
   // longest period of one oscillator half-cycle rounds down
   localparam int LPO_HALF_CYC    = int'($floor(CLK_FREQ_HZ / (2.0 * LPO_FREQ_HZ))) - 1;
   localparam int POR_TICKS       = 4;             // oscillator ticks the internal reset lasts
   localparam logic [RTC_CNT_W-1:0] RTC_RESET_VAL   = 48'h0000_0000_0000;
   localparam logic [WAKE2_W-1:0]   WAKE2_RESET_VAL = 34'h0_0000_0000;
   // aux output source select
   typedef enum logic [1:0] {
      RTCWK_AUX_OFF,
      RTCWK_AUX_TIMER,
      RTCWK_AUX_CLOCK
   } rtcwk_aux_mode_t;
endpackage : rtcwk_pkg

//--- hdl/rtcwk_wake_timer.sv
// rtcwk_wake_timer: wrapping wake-up counter with a one-clock-cycle match pulse.
// assumes tick_en is a one-cycle enable at the low-power oscillator rate.
`timescale 1ns/10ps
module rtcwk_wake_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,     // system clock
   input  wire logic             rst_n,   // async reset, active low
   input  wire logic             clr,     // internal power-on clear
   input  wire logic             tick_en, // oscillator tick
   input  wire logic [WIDTH-1:0] period,  // wrap value
   output logic                  hit      // pulse on wrap
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             hit;
   } rtcwk_tmr_t;
   rtcwk_tmr_t s_q, s_d;
   initial begin
      if (WIDTH < 2) $error("timer width too small");
   end
   always_comb begin
      s_d     = s_q;
      s_d.hit = 1'b0;
      if (clr) begin
         s_d.cnt = '0;
      end else if (tick_en) begin
         // one oscillator tick of resolution, wraps to zero at the period
         if (s_q.cnt >= period) begin
            s_d.cnt = '0;
            s_d.hit = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + WIDTH'(1);
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign hit = s_q.hit;
endmodule // rtcwk_wake_timer

//--- hdl/rtcwk_top.sv
// rtcwk_top: always-on time counter, wake-up timers, supply enable and alarm timestamping.
// assumes all inputs synchronous to MCLK; configuration held steady by the active system.
// Overview of operation
// - a 48-bit free-running time counter, 46 bits effective, advances each oscillator tick
// - the time counter wraps from all ones in its 46 effective bits back to all zeros, upper two bits stay zero
// - the internal power-on reset clears the time counter
// - supply enable stays low during power-on reset, goes high when it completes
// - two periodic outputs: supply enable for a regulator, auxiliary for a sensor
// - both wake-up counters wrap to zero on reaching their programmed period, giving repeating wake-ups
// - wake-up timers resolve a single oscillator cycle
// - auxiliary output is disabled, driven by the second wake-up counter, or driven by the oscillator clock
// - the second wake-up counter is 34 bits wide
// - auxiliary output may carry the oscillator clock itself
// - power-on reset clears the second wake-up counter
// - any change on either wake input drives supply enable high
// - any change on either wake input captures the time counter as timestamp
// - each wake input has its own programmable active polarity
// - each event is timestamped and raises an interrupt when powered on
// - a 128 by 32 battery-backed storage array retains its contents
`timescale 1ns/10ps
module rtcwk_top
   import rtcwk_pkg::*;
#(
   parameter int CNT_W   = rtcwk_pkg::RTC_CNT_W,
   parameter int EFF_W   = rtcwk_pkg::RTC_EFF_W,
   parameter int W1_W    = rtcwk_pkg::WAKE1_W,
   parameter int W2_W    = rtcwk_pkg::WAKE2_W,
   parameter int HALF_CY = rtcwk_pkg::LPO_HALF_CYC
) (
   input  wire logic                   MCLK,           // 40 MHz system clock
   input  wire logic                   NRST,           // async reset, active low
   input  wire logic                   WAKE_INPUT_A,   // external alarm input a
   input  wire logic                   WAKE_INPUT_B,   // external alarm input b
   input  wire logic                   POL_A,          // 1: input a active high
   input  wire logic                   POL_B,          // 1: input b active high
   input  wire logic                   SYS_POWERED,    // system in powered-on state
   input  wire logic                   SUPPLY_OFF,     // pulse: software drops supply enable
   input  wire logic [W1_W-1:0]        WAKE1_PERIOD,   // first wake-up period, ticks
   input  wire logic [W2_W-1:0]        WAKE2_PERIOD,   // second wake-up period, ticks
   input  wire rtcwk_pkg::rtcwk_aux_mode_t AUX_MODE,   // auxiliary output source
   input  wire logic                   AUX_INVERT,     // invert auxiliary output
   input  wire logic                   EVT_ACK,        // pulse: clear event interrupt
   input  wire logic                   RAM_WE,         // storage write strobe
   input  wire logic [RAM_ADDR_W-1:0]  RAM_ADDR,       // storage word address
   input  wire logic [RAM_WORD_W-1:0]  RAM_WDATA,      // storage write data
   output logic [RAM_WORD_W-1:0]       RAM_RDATA,      // storage read data, one cycle late
   output logic                        SUPPLY_ENABLE_PIN, // regulator enable
   output logic                        PERIODIC_AUX_PIN,  // sensor control output
   output logic [CNT_W-1:0]            TIME_NOW,       // live time counter
   output logic [CNT_W-1:0]            TIMESTAMP,      // time of last wake event
   output logic [1:0]                  EVT_SRC,        // which inputs changed last
   output logic                        EVT_IRQ         // event interrupt, level
);
   initial begin
      if (EFF_W > CNT_W || EFF_W < 1) $error("bad effective width");
      if (HALF_CY < 1) $error("oscillator divider too small");
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [15:0]      div;
      logic             lpo;        // oscillator clock image
      logic             tick;
      logic [3:0]       por_cnt;
      logic             por;        // internal power-on reset active
      logic [CNT_W-1:0] rtc;
      logic [1:0]       sync1;
      logic [1:0]       sync2;
      logic [1:0]       prev;
      logic             primed;
      logic             supply;
      logic             aux_lvl;
      logic             aux;
      logic [CNT_W-1:0] stamp;
      logic [1:0]       src;
      logic             irq;
      logic [RAM_WORD_W-1:0] rdata;
   } rtcwk_state_t;
   rtcwk_state_t s_q, s_d;

   logic [RAM_WORD_W-1:0] store_mem [RAM_WORDS];
   logic                  hit1;
   logic                  hit2;
   logic [1:0]            chg;

   function automatic logic [CNT_W-1:0] rtc_inc(input logic [CNT_W-1:0] v);
      logic [CNT_W-1:0] r;
      r = '0;
      r[EFF_W-1:0] = v[EFF_W-1:0] + EFF_W'(1);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // wake-up timers
   rtcwk_wake_timer #(.WIDTH(W1_W)) u_wake1 (
      .clk     (MCLK),
      .rst_n   (NRST),
      .clr     (s_q.por),
      .tick_en (s_q.tick),
      .period  (WAKE1_PERIOD),
      .hit     (hit1)
   );
   rtcwk_wake_timer #(.WIDTH(W2_W)) u_wake2 (
      .clk     (MCLK),
      .rst_n   (NRST),
      .clr     (s_q.por),
      .tick_en (s_q.tick),
      .period  (WAKE2_PERIOD),
      .hit     (hit2)
   );

   assign chg = s_q.sync2 ^ s_q.prev;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      // oscillator image and tick enable
      // a half cycle of the oscillator image lasts HALF_CY + 1 clocks
      if (s_q.div >= 16'(HALF_CY)) begin
         s_d.div = '0;
         s_d.lpo = ~s_q.lpo;
         s_d.tick = ~s_q.lpo;
      end else begin
         s_d.div = s_q.div + 16'h0001;
      end
      // internal power-on reset, a few oscillator ticks long
      if (s_q.por && s_q.tick) begin
         if (s_q.por_cnt == 4'(POR_TICKS - 1)) begin
            s_d.por = 1'b0;
         end else begin
            s_d.por_cnt = s_q.por_cnt + 4'h1;
         end
      end
      // time counter
      if (s_q.por) begin
         s_d.rtc = RTC_RESET_VAL;
      end else if (s_q.tick) begin
         s_d.rtc = rtc_inc(s_q.rtc);
      end
      // wake inputs, polarity applied, sampled on oscillator ticks
      if (s_q.tick) begin
         s_d.sync1 = {WAKE_INPUT_B ~^ POL_B, WAKE_INPUT_A ~^ POL_A};
         s_d.sync2 = s_q.sync1;
         s_d.prev  = s_q.sync2;
         s_d.primed = 1'b1;
      end
      // supply enable: low through the internal reset, high on the tick that ends it
      if (s_q.por) begin
         s_d.supply = s_q.tick && s_q.por_cnt == 4'(POR_TICKS - 1);
      end else if (SUPPLY_OFF) begin
         s_d.supply = 1'b0;
      end
      // events: edges are judged once per tick after the pipeline has filled
      if (s_q.tick && s_q.primed && !s_q.por && chg != 2'b00) begin
         s_d.supply = 1'b1;
         s_d.stamp  = s_q.rtc;
         s_d.src    = chg;
      end
      // event interrupt: set wins over clear
      if (EVT_ACK) begin
         s_d.irq = 1'b0;
      end
      if (s_q.tick && s_q.primed && !s_q.por && chg != 2'b00 && SYS_POWERED) begin
         s_d.irq = 1'b1;
      end
      // auxiliary output
      if (s_q.por) begin
         s_d.aux_lvl = 1'b0;
      end else if (hit2) begin
         s_d.aux_lvl = ~s_q.aux_lvl;
      end
      unique case (AUX_MODE)
         RTCWK_AUX_OFF:   s_d.aux = AUX_INVERT;
         RTCWK_AUX_TIMER: s_d.aux = s_d.aux_lvl ^ AUX_INVERT;
         RTCWK_AUX_CLOCK: s_d.aux = s_d.lpo ^ AUX_INVERT;
         default:         s_d.aux = AUX_INVERT;
      endcase
      // first wake-up counter wakes the system
      if (hit1 && !s_q.por) begin
         s_d.supply = 1'b1;
      end
      s_d.rdata = store_mem[RAM_ADDR];
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         s_q     <= '0;
         s_q.por <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // storage array has no reset so its contents survive
   always_ff @(posedge MCLK) begin
      if (RAM_WE) begin
         store_mem[RAM_ADDR] <= RAM_WDATA;
      end
   end

   assign RAM_RDATA         = s_q.rdata;
   assign SUPPLY_ENABLE_PIN = s_q.supply;
   assign PERIODIC_AUX_PIN  = s_q.aux;
   assign TIME_NOW          = s_q.rtc;
   assign TIMESTAMP         = s_q.stamp;
   assign EVT_SRC           = s_q.src;
   assign EVT_IRQ           = s_q.irq;
endmodule // rtcwk_top

//--- tb/rtcwk_assertions.sv
// rtcwk_assertions: port checks of time counter, supply enable, events and aux output.
// assumes a bind to rtcwk_top; MCLK and NRST form the only domain.
`timescale 1ns/10ps
module rtcwk_assertions
   import rtcwk_pkg::*;
#(
   parameter int CNT_W   = 48,
   parameter int HALF_CY = 2
) (
   input wire logic                   MCLK,              // clock
   input wire logic                   NRST,              // reset, active low
   input wire logic                   SYS_POWERED,       // powered state
   input wire logic                   EVT_ACK,           // interrupt clear
   input wire rtcwk_pkg::rtcwk_aux_mode_t AUX_MODE,      // aux source
   input wire logic                   AUX_INVERT,        // aux inversion
   input wire logic                   SUPPLY_ENABLE_PIN, // regulator enable
   input wire logic                   PERIODIC_AUX_PIN,  // sensor output
   input wire logic [CNT_W-1:0]       TIME_NOW,          // time counter
   input wire logic [CNT_W-1:0]       TIMESTAMP,         // event time
   input wire logic                   EVT_IRQ            // event interrupt
);
   localparam int POR_CYC = 6 * (HALF_CY + 1);
   logic [9:0] por_cnt_q;
   // cycles since reset release, a safe lower bound for the internal reset
   always_ff @(posedge MCLK or negedge NRST)
      if (!NRST)
         por_cnt_q <= 10'h000;
      else if (por_cnt_q != 10'h3ff)
         por_cnt_q <= por_cnt_q + 10'h001;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   sequence s_aux_idle;
      (AUX_MODE == RTCWK_AUX_OFF && $stable(AUX_INVERT)) [*2];
   endsequence
   sequence s_new_event;
      $changed(TIMESTAMP);
   endsequence
   ////////////////////////////////////////////////////////////////
   a_time_top_zero: assert property (TIME_NOW[CNT_W-1:CNT_W-2] == 2'h0)
      else $error("time counter upper bits set");
   a_time_step_one: assert property ($changed(TIME_NOW) |-> TIME_NOW[CNT_W-3:0] == $past(TIME_NOW[CNT_W-3:0]) + 46'h1)
      else $error("time counter did not step by one");
   a_por_hold_low: assert property (por_cnt_q < POR_CYC |-> !SUPPLY_ENABLE_PIN && TIME_NOW == '0)
      else $error("supply or time active during internal reset");
   a_event_wakes_supply: assert property (s_new_event |-> SUPPLY_ENABLE_PIN)
      else $error("event without supply enable");
   a_stamp_is_time: assert property (s_new_event |-> TIMESTAMP == TIME_NOW || TIMESTAMP + 1 == TIME_NOW)
      else $error("timestamp differs from time counter");
   a_irq_when_powered: assert property ($rose(EVT_IRQ) |-> $past(SYS_POWERED) && $changed(TIMESTAMP))
      else $error("interrupt without powered event");
   a_ack_clears_irq: assert property (EVT_ACK |=> !EVT_IRQ || $changed(TIMESTAMP))
      else $error("interrupt not cleared");
   a_aux_off_level: assert property (s_aux_idle |-> PERIODIC_AUX_PIN == AUX_INVERT)
      else $error("aux level wrong while disabled");
endmodule // rtcwk_assertions

//--- tb/rtcwk_event_src.sv
// rtcwk_event_src: far-side event source flipping the two wake lines on request.
// assumes requests are one-cycle pulses at least one oscillator tick apart.
`timescale 1ns/10ps
module rtcwk_event_src (
   input  wire logic clk,    // system clock
   input  wire logic flip_a, // request: change line a
   input  wire logic flip_b, // request: change line b
   output logic      wake_a, // wake line a
   output logic      wake_b  // wake line b
);
   initial begin
      wake_a = 1'b0;
      wake_b = 1'b0;
   end
   // a level holds until the next request, never narrower than a tick
   always @(posedge clk) begin
      if (flip_a)
         wake_a <= ~wake_a;
      if (flip_b)
         wake_b <= ~wake_b;
   end
endmodule // rtcwk_event_src

//--- tb/rtcwk_top_tb.sv
// rtcwk_top_tb: self-checking bench of the always-on counter and wake-up control.
// assumes HALF_CY of 2, so one oscillator tick is six MCLK cycles.
`timescale 1ns/10ps
module rtcwk_top_tb;
   import rtcwk_pkg::*;
   localparam int TK = 6;
   logic            mclk, nrst, pol_a, pol_b, pwr, s_off, inv, ack, we, fa, fb, wa, wb, sup, aux, irq;
   logic [31:0]     p1, wdat, rdat;
   logic [33:0]     p2;
   logic [6:0]      addr;
   logic [47:0]     tnow, tstamp;
   logic [1:0]      src;
   rtcwk_aux_mode_t mode;
   int              err_count, samples_checked, cyc;
   rtcwk_top #(.HALF_CY(2)) u_rtcwk_top (.MCLK(mclk), .NRST(nrst), .WAKE_INPUT_A(wa), .WAKE_INPUT_B(wb),
      .POL_A(pol_a), .POL_B(pol_b), .SYS_POWERED(pwr), .SUPPLY_OFF(s_off), .WAKE1_PERIOD(p1), .WAKE2_PERIOD(p2),
      .AUX_MODE(mode), .AUX_INVERT(inv), .EVT_ACK(ack), .RAM_WE(we), .RAM_ADDR(addr), .RAM_WDATA(wdat),
      .RAM_RDATA(rdat), .SUPPLY_ENABLE_PIN(sup), .PERIODIC_AUX_PIN(aux), .TIME_NOW(tnow), .TIMESTAMP(tstamp),
      .EVT_SRC(src), .EVT_IRQ(irq));
   rtcwk_event_src u_rtcwk_event_src (.clk(mclk), .flip_a(fa), .flip_b(fb), .wake_a(wa), .wake_b(wb));
   initial begin
      mclk = 1'b0;
      cyc = 0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_hi(input int lim, output int n);
      n = 0;
      while (sup !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > lim) begin
            err_count++;
            $display("Error supply wait expected 1 seen %b", sup);
            print_verdict();
         end
      end
   endtask
   task automatic pulse_off();
      s_off = 1'b1;
      @(negedge mclk);
      s_off = 1'b0;
   endtask
   task automatic do_reset(input logic [31:0] a, input logic [33:0] b);
      int n;
      nrst = 1'b0;
      p1 = a;
      p2 = b;
      repeat (8) @(negedge mclk);
      chk("supply in reset", 48'h0, {47'h0, sup});
      nrst = 1'b1;
      wait_hi(6*TK, n);
      chk("internal reset long", 48'h1, {47'h0, n >= 3*TK - 1});
      chk("time after reset", 48'h0, {1'b0, tnow[47:1]});
   endtask
   task automatic t_wake(input int k);
      int n;
      pwr = (k < 2);
      pulse_off();
      chk("supply off", 48'h0, {47'h0, sup});
      case (k)
         0: fa = 1'b1;
         1: fb = 1'b1;
         2: pol_a = ~pol_a;
         default: pol_b = ~pol_b;
      endcase
      @(negedge mclk);
      fa = 1'b0;
      fb = 1'b0;
      wait_hi(4*TK+2, n);
      chk("stamp", 48'h1, {47'h0, (tnow - tstamp) <= 48'h1});
      chk("source", {46'h0, k[0], ~k[0]}, {46'h0, src});
      chk("irq", {47'h0, (k < 2)}, {47'h0, irq});
      ack = 1'b1;
      @(negedge mclk);
      ack = 1'b0;
      chk("irq ack", 48'h0, {47'h0, irq});
   endtask
   task automatic aux_gap(output int d);
      logic v;
      for (int i = 0; i < 2; i++) begin
         v = aux;
         d = 0;
         while (aux === v && d < 40) begin
            @(negedge mclk);
            d++;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      int t0;
      int d;
      {nrst, pol_a, pol_b, pwr, s_off, inv, ack, we, fa, fb} = 10'h200;
      addr = 7'h00;
      wdat = 32'h0;
      mode = RTCWK_AUX_OFF;
      err_count = 0;
      samples_checked = 0;
      do_reset(32'hffff_ffff, 34'h3_ffff_ffff);
      t0 = tnow;
      repeat (10*TK) @(negedge mclk);
      chk("time advance", 48'd10, tnow - t0);
      for (int k = 0; k < 4; k++)
         t_wake(k);
      we = 1'b1;
      wdat = 32'h5a5a_0001;
      @(negedge mclk);
      addr = 7'h7f;
      wdat = 32'ha5a5_007f;
      @(negedge mclk);
      we = 1'b0;
      mode = RTCWK_AUX_TIMER;
      do_reset(32'h0000_0003, 34'h0_0000_0001);
      addr = 7'h00;
      @(negedge mclk);
      chk("ram low word", 48'h5a5a_0001, {16'h0, rdat});
      addr = 7'h7f;
      @(negedge mclk);
      chk("ram top word", 48'ha5a5_007f, {16'h0, rdat});
      for (int i = 0; i < 2; i++) begin
         pulse_off();
         wait_hi(6*TK, d);
         if (i == 1)
            chk("wake period", 4*TK, cyc - t0);
         t0 = cyc;
      end
      aux_gap(d);
      chk("aux timer gap", 2*TK, d);
      mode = RTCWK_AUX_CLOCK;
      aux_gap(d);
      chk("aux clock gap", TK/2, d);
      for (int v = 0; v < 2; v++) begin
         mode = RTCWK_AUX_OFF;
         inv = v[0];
         repeat (2) @(negedge mclk);
         chk("aux off level", v, aux);
      end
      print_verdict();
   end
endmodule // rtcwk_top_tb

bind rtcwk_top rtcwk_assertions #(.CNT_W(CNT_W), .HALF_CY(HALF_CY)) u_rtcwk_assertions (.MCLK(MCLK), .NRST(NRST),
   .SYS_POWERED(SYS_POWERED), .EVT_ACK(EVT_ACK), .AUX_MODE(AUX_MODE), .AUX_INVERT(AUX_INVERT),
   .SUPPLY_ENABLE_PIN(SUPPLY_ENABLE_PIN), .PERIODIC_AUX_PIN(PERIODIC_AUX_PIN), .TIME_NOW(TIME_NOW),
   .TIMESTAMP(TIMESTAMP), .EVT_IRQ(EVT_IRQ));
